// file: hw/pcs_pkg.sv
// Constants shared by the auxiliary port / chip-select strobe block
package pcs_pkg;

  // Special function register addresses
  localparam logic [7:0] PCS_OFS_PINS01_CTRL   = 8'h92;
  localparam logic [7:0] PCS_OFS_PINS23_CTRL   = 8'h93;
  localparam logic [7:0] PCS_OFS_POLARITY_MISC = 8'hA2;
  localparam logic [7:0] PCS_OFS_PORT_DATA     = 8'hA5;
  // Base address registers: high byte of pin n at BASE_HI + 2n, low byte at BASE_HI + 2n + 1
  localparam logic [7:0] PCS_OFS_BASE_HI0      = 8'hB4;

  // Field positions inside a pin-pair control register (pin pair stride 4)
  localparam int PCS_CMP_LSB       = 0;
  localparam int PCS_FUNC_LSB      = 2;
  localparam int PCS_PAIR_STRIDE   = 4;
  // Field positions inside the polarity / misc register
  localparam int PCS_PUP_BIT       = 0;
  localparam int PCS_RMW_BIT       = 1;
  localparam int PCS_POWERDOWN_STROBE_HOLD_BIT     = 2;
  localparam int PCS_LEVEL_LSB     = 4;

  // Pin function select codes
  localparam logic [1:0] PCS_FUNC_GPIO  = 2'h0;
  localparam logic [1:0] PCS_FUNC_RD    = 2'h1;
  localparam logic [1:0] PCS_FUNC_WR    = 2'h2;
  localparam logic [1:0] PCS_FUNC_RDWR  = 2'h3;

  // Compare width select codes
  localparam logic [1:0] PCS_CMP_A15_A0 = 2'h0;
  localparam logic [1:0] PCS_CMP_A15_A1 = 2'h1;
  localparam logic [1:0] PCS_CMP_A15_A2 = 2'h2;
  localparam logic [1:0] PCS_CMP_A15_A8 = 2'h3;

  // Reset values
  localparam logic [7:0] PCS_CTRL_RST   = 8'h00;
  localparam logic [7:0] PCS_POL_RST    = 8'h00;
  localparam logic [7:0] PCS_BASE_RST   = 8'h00;
  localparam logic [3:0] PCS_PORT_RST   = 4'hF;
  // Mask of implemented polarity register bits (bit 3 reserved)
  localparam logic [7:0] PCS_POL_MASK   = 8'hF7;

endpackage

// file: hw/pcs_addr_match.sv
// Address comparator and strobe qualifier for one chip-select pin
`timescale 1ns/1ps
module pcs_addr_match
  import pcs_pkg::*;
(
  input  wire logic [15:0] base_addr,
  input  wire logic [1:0]  cmp_width,
  input  wire logic [1:0]  func_sel,
  input  wire logic [15:0] ext_addr,
  input  wire logic        ext_rd,
  input  wire logic        ext_wr,
  output logic             hit
);

  logic [15:0] mask;
  logic        addr_eq;
  logic        phase_ok;

  always_comb begin
    case (cmp_width)
      PCS_CMP_A15_A0: mask = 16'hFFFF;
      PCS_CMP_A15_A1: mask = 16'hFFFE;
      PCS_CMP_A15_A2: mask = 16'hFFFC;
      PCS_CMP_A15_A8: mask = 16'hFF00;
      default:        mask = 16'hFFFF;
    endcase
  end

  assign addr_eq = ((ext_addr ^ base_addr) & mask) == 16'h0000;

  always_comb begin
    case (func_sel)
      PCS_FUNC_RD:   phase_ok = ext_rd;
      PCS_FUNC_WR:   phase_ok = ext_wr;
      PCS_FUNC_RDWR: phase_ok = ext_rd | ext_wr;
      default:       phase_ok = 1'b0;
    endcase
  end

  // Asserted only inside the bus strobe phase
  assign hit = addr_eq & phase_ok;

endmodule

// file: hw/pcs_port4.sv
// Four-pin auxiliary port with programmable chip-select strobes
`timescale 1ns/1ps
// Summary of operation
// - Function 00: pin is quasi-bidirectional GPIO
// - Function 01: strobe on matching external reads
// - Function 10: strobe on matching external writes
// - Function 11: strobe on matching reads and writes
// - Compare 00: all sixteen address bits
// - Compare 01: bits fifteen to one only
// - Compare 10: bits fifteen to two only
// - Compare 11: bits fifteen to eight only
// - Each pin has high and low base bytes
// - Pins 0/1 control register field layout
// - Pins 2/3 control register, same layout
// - Polarity bit per pin: one active high
// - Port data low nibble drives GPIO pins
// - Power-down: hold bit sets ALE/program strobe
// - RMW reads pins or latch per bit
// - Pull-up bit enables address/data port pull-ups
// - Matching external data write pulses write strobe
module pcs_port4
  import pcs_pkg::*;
#(
  parameter int NPINS = 4
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // SFR access from the CPU core
  input  wire logic [7:0]        sfr_addr,
  input  wire logic [7:0]        sfr_wdata,
  input  wire logic              sfr_wr,
  input  wire logic              sfr_rd,
  input  wire logic              sfr_rmw,
  output logic      [7:0]        sfr_rdata,
  output logic                   sfr_hit,
  // External data bus cycle from the core
  input  wire logic [15:0]       ext_addr,
  input  wire logic              ext_rd,
  input  wire logic              ext_wr,
  // Pins
  input  wire logic [NPINS-1:0]  pin_in,
  output logic      [NPINS-1:0]  pin_out,
  output logic      [NPINS-1:0]  pin_oe,
  // Power-down and neighbouring pins
  input  wire logic              powerdown,
  input  wire logic              ale_core,
  input  wire logic              program_store_strobe_core,
  output logic                   ale_out,
  output logic                   program_store_strobe_out,
  output logic                   addr_data_port_pullup_en
);

  logic [7:0]       pins01_function_ctrl_reg;
  logic [7:0]       pins23_function_ctrl_reg;
  logic [7:0]       strobe_polarity_misc_reg;
  logic [3:0]       aux_port_data_reg;
  logic [7:0]       base_hi_reg [NPINS];
  logic [7:0]       base_lo_reg [NPINS];
  logic [NPINS-1:0] hit;
  logic [NPINS-1:0] strobe_level;
  logic [NPINS-1:0] cs_mode;
  logic [7:0]       rdata_next;
  logic             hit_next;

  // Function select field of one pin
  function automatic logic [1:0] func_of(input logic [7:0] c01, input logic [7:0] c23, input int idx);
    logic [7:0] c;
    c = (idx < 2) ? c01 : c23;
    return c[PCS_FUNC_LSB + PCS_PAIR_STRIDE*(idx%2) +: 2];
  endfunction

  // Compare width field of one pin
  function automatic logic [1:0] cmp_of(input logic [7:0] c01, input logic [7:0] c23, input int idx);
    logic [7:0] c;
    c = (idx < 2) ? c01 : c23;
    return c[PCS_CMP_LSB + PCS_PAIR_STRIDE*(idx%2) +: 2];
  endfunction

  // Register index of a base address byte, or -1
  function automatic int base_index(input logic [7:0] a);
    int d;
    d = int'(a) - int'(PCS_OFS_BASE_HI0);
    return (d >= 0 && d < 2*NPINS) ? d : -1;
  endfunction

  assign strobe_level = strobe_polarity_misc_reg[PCS_LEVEL_LSB +: NPINS];

  // Configuration register writes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pins01_function_ctrl_reg <= PCS_CTRL_RST;
      pins23_function_ctrl_reg <= PCS_CTRL_RST;
      strobe_polarity_misc_reg <= PCS_POL_RST;
    end else if (sfr_wr) begin
      if (sfr_addr == PCS_OFS_PINS01_CTRL) begin
        pins01_function_ctrl_reg <= sfr_wdata;
      end
      if (sfr_addr == PCS_OFS_PINS23_CTRL) begin
        pins23_function_ctrl_reg <= sfr_wdata;
      end
      if (sfr_addr == PCS_OFS_POLARITY_MISC) begin
        strobe_polarity_misc_reg <= sfr_wdata & PCS_POL_MASK;
      end
    end
  end

  // Port data latch; upper nibble has no storage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aux_port_data_reg <= PCS_PORT_RST;
    end else if (sfr_wr && sfr_addr == PCS_OFS_PORT_DATA) begin
      aux_port_data_reg <= sfr_wdata[3:0];
    end
  end

  // Base address bytes, high then low per pin
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NPINS; i++) begin
        base_hi_reg[i] <= PCS_BASE_RST;
        base_lo_reg[i] <= PCS_BASE_RST;
      end
    end else if (sfr_wr && base_index(sfr_addr) >= 0) begin
      if (base_index(sfr_addr) % 2 == 0) begin
        base_hi_reg[base_index(sfr_addr) / 2] <= sfr_wdata;
      end else begin
        base_lo_reg[base_index(sfr_addr) / 2] <= sfr_wdata;
      end
    end
  end

  // Per-pin comparator and output stage
  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_pin
      pcs_addr_match u_match (
        .base_addr ({base_hi_reg[g], base_lo_reg[g]}),
        .cmp_width (cmp_of(pins01_function_ctrl_reg, pins23_function_ctrl_reg, g)),
        .func_sel  (func_of(pins01_function_ctrl_reg, pins23_function_ctrl_reg, g)),
        .ext_addr  (ext_addr),
        .ext_rd    (ext_rd),
        .ext_wr    (ext_wr),
        .hit       (hit[g])
      );

      // Registered pin drive: strobes lag the bus strobe by one clock
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          pin_out[g] <= 1'b0;
          pin_oe[g]  <= 1'b0;
        end else if (func_of(pins01_function_ctrl_reg, pins23_function_ctrl_reg, g) == PCS_FUNC_GPIO) begin
          // Quasi-bidirectional: drive low only, a one is left to the pull-up
          pin_out[g] <= 1'b0;
          pin_oe[g]  <= ~aux_port_data_reg[g];
        end else begin
          pin_out[g] <= hit[g] ? strobe_level[g] : ~strobe_level[g];
          pin_oe[g]  <= 1'b1;
        end
      end

      // Strobe mode flag, shared by the checks below
      assign cs_mode[g] = func_of(pins01_function_ctrl_reg, pins23_function_ctrl_reg, g) != PCS_FUNC_GPIO;

      // A strobe line is never released, or the peripheral would see a floating select
      cs_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cs_mode[g] |=> pin_oe[g])
        else $error("strobe pin not driven");
      gpio_pin_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !cs_mode[g] |=> !pin_out[g] && pin_oe[g] == ~$past(aux_port_data_reg[g]))
        else $error("gpio pin level wrong");
    end
  endgenerate

  // Read data mux
  always_comb begin
    rdata_next = 8'h00;
    hit_next   = 1'b1;
    if (sfr_addr == PCS_OFS_PINS01_CTRL) begin
      rdata_next = pins01_function_ctrl_reg;
    end else if (sfr_addr == PCS_OFS_PINS23_CTRL) begin
      rdata_next = pins23_function_ctrl_reg;
    end else if (sfr_addr == PCS_OFS_POLARITY_MISC) begin
      rdata_next = strobe_polarity_misc_reg;
    end else if (sfr_addr == PCS_OFS_PORT_DATA) begin
      // Plain reads see the pins; RMW reads see the latch unless redirected
      if (sfr_rmw && !strobe_polarity_misc_reg[PCS_RMW_BIT]) begin
        rdata_next = {4'h0, aux_port_data_reg};
      end else begin
        rdata_next = {4'h0, pin_in};
      end
    end else if (base_index(sfr_addr) >= 0) begin
      if (base_index(sfr_addr) % 2 == 0) begin
        rdata_next = base_hi_reg[base_index(sfr_addr) / 2];
      end else begin
        rdata_next = base_lo_reg[base_index(sfr_addr) / 2];
      end
    end else begin
      hit_next = 1'b0;
    end
  end

  // Read data is held until the next read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
      sfr_hit   <= 1'b0;
    end else if (sfr_rd) begin
      sfr_rdata <= rdata_next;
      sfr_hit   <= hit_next;
    end
  end

  // Power-down handling of ALE and program store strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ale_out                  <= 1'b0;
      program_store_strobe_out <= 1'b0;
    end else if (powerdown) begin
      ale_out                  <= strobe_polarity_misc_reg[PCS_POWERDOWN_STROBE_HOLD_BIT];
      program_store_strobe_out <= strobe_polarity_misc_reg[PCS_POWERDOWN_STROBE_HOLD_BIT];
    end else begin
      ale_out                  <= ale_core;
      program_store_strobe_out <= program_store_strobe_core;
    end
  end

  assign addr_data_port_pullup_en = strobe_polarity_misc_reg[PCS_PUP_BIT];

  // Checks on pin 0, plus power-down hold, RMW read path and idle strobes of all pins
  logic [1:0]  f0;
  logic [1:0]  c0;
  logic [15:0] b0;
  assign f0 = pins01_function_ctrl_reg[3:2];
  assign c0 = pins01_function_ctrl_reg[1:0];
  assign b0 = {base_hi_reg[0], base_lo_reg[0]};

  gpio_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    f0 == PCS_FUNC_GPIO |=> pin_oe[0] == ~$past(aux_port_data_reg[0]) && !pin_out[0])
    else $error("gpio pin drive wrong");
  read_strobe_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    f0 == PCS_FUNC_RD && ext_rd && ((ext_addr ^ b0) & 16'hFF00) == 16'h0000 && c0 == PCS_CMP_A15_A8
    |=> pin_out[0] == $past(strobe_level[0]))
    else $error("read strobe missing");
  write_only_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    f0 == PCS_FUNC_WR && !ext_wr |=> pin_out[0] == ~$past(strobe_level[0]))
    else $error("write strobe on non-write");
  both_dir_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    f0 == PCS_FUNC_RDWR && (ext_rd || ext_wr) && ext_addr == b0 |=> pin_out[0] == $past(strobe_level[0]))
    else $error("rd/wr strobe missing");
  full_cmp_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    f0 != PCS_FUNC_GPIO && c0 == PCS_CMP_A15_A0 && ext_addr != b0 |=> pin_out[0] == ~$past(strobe_level[0]))
    else $error("full compare mismatch strobed");
  two_byte_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    f0 == PCS_FUNC_RDWR && c0 == PCS_CMP_A15_A1 && ext_rd && ext_addr[15:1] == b0[15:1]
    |=> pin_out[0] == $past(strobe_level[0]))
    else $error("two byte region missed");
  four_byte_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    f0 == PCS_FUNC_WR && c0 == PCS_CMP_A15_A2 && ext_wr && ext_addr[15:2] != b0[15:2]
    |=> pin_out[0] == ~$past(strobe_level[0]))
    else $error("outside four byte region strobed");
  base_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sfr_wr && sfr_addr == PCS_OFS_BASE_HI0 |=> base_hi_reg[0] == $past(sfr_wdata))
    else $error("base high byte not stored");
  power_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    powerdown |=> ale_out == $past(strobe_polarity_misc_reg[PCS_POWERDOWN_STROBE_HOLD_BIT])
                  && program_store_strobe_out == ale_out)
    else $error("power-down strobe level wrong");
  rmw_path_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sfr_rd && sfr_rmw && sfr_addr == PCS_OFS_PORT_DATA && !strobe_polarity_misc_reg[PCS_RMW_BIT]
    |=> sfr_rdata == {4'h0, $past(aux_port_data_reg)})
    else $error("rmw read not from latch");
  strobe_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !ext_rd && !ext_wr |=> (pin_out & $past(cs_mode)) == (~$past(strobe_level) & $past(cs_mode)))
    else $error("strobe outside bus phase");

  wr_strobe_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    f0 == PCS_FUNC_WR && hit[0] ##1 pin_out[0] == strobe_level[0]);
  rd_strobe_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    f0 == PCS_FUNC_RD && hit[0]);
  gpio_low_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    f0 == PCS_FUNC_GPIO && pin_oe[0]);
  pd_hold_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    powerdown && strobe_polarity_misc_reg[PCS_POWERDOWN_STROBE_HOLD_BIT] ##1 ale_out);
  rmw_pin_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    sfr_rd && sfr_rmw && strobe_polarity_misc_reg[PCS_RMW_BIT]);

  // Register stores and read-back
  cfg01_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sfr_wr && sfr_addr == PCS_OFS_PINS01_CTRL |=> pins01_function_ctrl_reg == $past(sfr_wdata))
    else $error("pin 0/1 control not stored");
  cfg23_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sfr_wr && sfr_addr == PCS_OFS_PINS23_CTRL |=> pins23_function_ctrl_reg == $past(sfr_wdata))
    else $error("pin 2/3 control not stored");
  level_store_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sfr_wr && sfr_addr == PCS_OFS_POLARITY_MISC |=> strobe_polarity_misc_reg == ($past(sfr_wdata) & PCS_POL_MASK))
    else $error("polarity register not stored");
  port_latch_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sfr_wr && sfr_addr == PCS_OFS_PORT_DATA |=> aux_port_data_reg == $past(sfr_wdata[3:0]))
    else $error("port latch not stored");
  base_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sfr_wr && sfr_addr == PCS_OFS_BASE_HI0 + 8'h01 |=> base_lo_reg[0] == $past(sfr_wdata))
    else $error("base low byte not stored");
  ctrl_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sfr_rd && sfr_addr == PCS_OFS_PINS01_CTRL |=> sfr_hit && sfr_rdata == $past(pins01_function_ctrl_reg))
    else $error("pin 0/1 control read wrong");
  pol_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sfr_rd && sfr_addr == PCS_OFS_POLARITY_MISC |=> sfr_rdata == $past(strobe_polarity_misc_reg))
    else $error("polarity read wrong");
  unmapped_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sfr_rd && sfr_addr == 8'h80 |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("unmapped read not refused");

  // Port data reads
  plain_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sfr_rd && !sfr_rmw && sfr_addr == PCS_OFS_PORT_DATA |=> sfr_rdata == {4'h0, $past(pin_in)})
    else $error("plain port read not from pins");
  rmw_pins_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sfr_rd && sfr_rmw && sfr_addr == PCS_OFS_PORT_DATA && strobe_polarity_misc_reg[PCS_RMW_BIT]
    |=> sfr_rdata == {4'h0, $past(pin_in)})
    else $error("rmw read not from pins");

  // Strobe regions
  write_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    f0 == PCS_FUNC_WR && c0 == PCS_CMP_A15_A2 && ext_wr && ext_addr[15:2] == b0[15:2]
    |=> pin_out[0] == $past(strobe_level[0]))
    else $error("write strobe pulse missing");
  high_byte_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    f0 == PCS_FUNC_RD && c0 == PCS_CMP_A15_A8 && ext_rd && ext_addr[15:8] != b0[15:8]
    |=> pin_out[0] == ~$past(strobe_level[0]))
    else $error("outside high byte region strobed");

  // Reset and power-down
  // No disable here: the check must see the first edge after release
  reset_values_a: assert property (@(posedge clk_sys)
    $rose(rst_n) |-> pins01_function_ctrl_reg == PCS_CTRL_RST && pins23_function_ctrl_reg == PCS_CTRL_RST
                     && strobe_polarity_misc_reg == PCS_POL_RST && pin_oe == {NPINS{1'b0}})
    else $error("configuration not cleared by reset");
  pd_release_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !powerdown |=> ale_out == $past(ale_core) && program_store_strobe_out == $past(program_store_strobe_core))
    else $error("strobes not following core");

endmodule

// file: verif/pcs_periph_model.sv
// Far-side peripheral model: pull-up pin wires with optional external pull-down
`timescale 1ns/1ps
module pcs_periph_model (
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  input  wire logic [3:0] pull_low,
  output logic      [3:0] pin_level
);
  // A released pin rests at its pull-up unless the peripheral sinks it
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : ~pull_low[i];
    end
  end
endmodule

// file: verif/pcs_port4_tb.sv
// Self-checking bench for the auxiliary port strobe block
`timescale 1ns/1ps
module pcs_port4_tb;
  import pcs_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  logic [7:0]  sfr_wdata = 8'h00;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic        sfr_rmw = 1'b0;
  logic [7:0]  sfr_rdata;
  logic        sfr_hit;
  logic [15:0] ext_addr = 16'h0000;
  logic        ext_rd = 1'b0;
  logic        ext_wr = 1'b0;
  logic [3:0]  pin_in;
  logic [3:0]  pin_out;
  logic [3:0]  pin_oe;
  logic [3:0]  pull_low = 4'h0;
  logic        powerdown = 1'b0;
  logic        ale_core = 1'b0;
  logic        pss_core = 1'b0;
  logic        ale_out;
  logic        pss_out;
  logic        pup_en;
  int          bad_count = 0;
  int          n_tests = 0;

  always #4 clk_sys = ~clk_sys;

  pcs_port4 #(.NPINS(4)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .ext_addr(ext_addr), .ext_rd(ext_rd), .ext_wr(ext_wr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .powerdown(powerdown),
    .ale_core(ale_core), .program_store_strobe_core(pss_core), .ale_out(ale_out),
    .program_store_strobe_out(pss_out), .addr_data_port_pullup_en(pup_en)
  );

  pcs_periph_model i_periph (
    .pin_out(pin_out), .pin_oe(pin_oe), .pull_low(pull_low), .pin_level(pin_in)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
  endtask

  // Read data lands on the edge that takes the read, so it is judged one negedge later
  task automatic rd_chk(input logic [7:0] a, input logic rmw, input logic [7:0] exp, input logic hit);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_rmw = rmw;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    sfr_rmw = 1'b0;
    chk(16'({sfr_hit, sfr_rdata}), 16'({hit, exp}));
  endtask

  task automatic probe(input int p, input logic [15:0] a, input logic r, input logic hit, input logic pol);
    @(negedge clk_sys);
    ext_addr = a;
    ext_rd = r;
    ext_wr = ~r;
    @(negedge clk_sys);
    chk(16'({pin_oe[p], pin_out[p]}), 16'({1'b1, hit ? pol : ~pol}));
    ext_rd = 1'b0;
    ext_wr = 1'b0;
    @(negedge clk_sys);
    chk(16'(pin_out[p]), 16'({~pol}));
  endtask

  task automatic t_reset;
    chk(16'({pin_oe, pin_out}), 16'h0000);
    rd_chk(PCS_OFS_PINS01_CTRL, 1'b0, 8'h00, 1'b1);
    rd_chk(PCS_OFS_PINS23_CTRL, 1'b0, 8'h00, 1'b1);
    rd_chk(PCS_OFS_POLARITY_MISC, 1'b0, 8'h00, 1'b1);
    rd_chk(PCS_OFS_PORT_DATA, 1'b0, 8'h0F, 1'b1);
    for (int i = 0; i < 8; i++) begin
      rd_chk(8'(PCS_OFS_BASE_HI0 + i), 1'b0, 8'h00, 1'b1);
    end
    rd_chk(8'h80, 1'b0, 8'h00, 1'b0);
    $display("reset test done");
  endtask

  task automatic t_regs;
    wr(PCS_OFS_PINS01_CTRL, 8'hA5);
    wr(PCS_OFS_PINS23_CTRL, 8'h5A);
    wr(PCS_OFS_POLARITY_MISC, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      wr(8'(PCS_OFS_BASE_HI0 + i), 8'(8'h31 + 8'h11 * i));
    end
    rd_chk(PCS_OFS_PINS01_CTRL, 1'b0, 8'hA5, 1'b1);
    rd_chk(PCS_OFS_PINS23_CTRL, 1'b0, 8'h5A, 1'b1);
    rd_chk(PCS_OFS_POLARITY_MISC, 1'b0, 8'hF7, 1'b1);
    chk(16'(pup_en), 16'h0001);
    for (int i = 0; i < 8; i++) begin
      rd_chk(8'(PCS_OFS_BASE_HI0 + i), 1'b0, 8'(8'h31 + 8'h11 * i), 1'b1);
    end
    $display("register test done");
  endtask

  // Every pin, every compare width, all three strobe kinds; probes sit on the region edge
  task automatic t_strobe;
    logic [1:0]  f;
    logic        pol;
    logic [15:0] m;
    logic [7:0]  ca;
    // Pin 0 walks the function/width pairs its assertions watch: 11, 11, 10, 01
    logic [7:0]  f0_seq = 8'h6F;
    for (int p = 0; p < 4; p++) begin
      for (int w = 0; w < 4; w++) begin
        f = (p == 0) ? f0_seq[2 * w +: 2] : 2'((p + w) % 3 + 1);
        pol = 1'((p + w) % 2);
        m = (w == 0) ? 16'h0000 : (w == 1) ? 16'h0001 : (w == 2) ? 16'h0003 : 16'h00FF;
        ca = (p < 2) ? PCS_OFS_PINS01_CTRL : PCS_OFS_PINS23_CTRL;
        wr(ca, 8'({f, 2'(w)}) << (4 * (p % 2)));
        wr(8'(PCS_OFS_BASE_HI0 + 2 * p), 8'h12);
        wr(8'(PCS_OFS_BASE_HI0 + 2 * p + 1), 8'h34);
        wr(PCS_OFS_POLARITY_MISC, 8'({pol, 4'h0}) << p);
        for (int k = 0; k < 4; k++) begin
          probe(p, (16'h1234 | m) + 16'(k % 2), 1'(k / 2), (k % 2 == 0) && f[k < 2], pol);
        end
      end
    end
    $display("strobe test done");
  endtask

  task automatic t_gpio;
    wr(PCS_OFS_PINS01_CTRL, 8'h00);
    wr(PCS_OFS_PINS23_CTRL, 8'h00);
    wr(PCS_OFS_POLARITY_MISC, 8'h00);
    wr(PCS_OFS_PORT_DATA, 8'h05);
    @(negedge clk_sys);
    chk(16'({pin_oe, pin_out}), 16'h00A0);
    rd_chk(PCS_OFS_PORT_DATA, 1'b0, 8'h05, 1'b1);
    wr(PCS_OFS_PORT_DATA, 8'hFF);
    pull_low = 4'h1;
    rd_chk(PCS_OFS_PORT_DATA, 1'b1, 8'h0F, 1'b1);
    rd_chk(PCS_OFS_PORT_DATA, 1'b0, 8'h0E, 1'b1);
    wr(PCS_OFS_POLARITY_MISC, 8'h02);
    rd_chk(PCS_OFS_PORT_DATA, 1'b1, 8'h0E, 1'b1);
    pull_low = 4'h0;
    $display("gpio test done");
  endtask

  task automatic t_pdown;
    wr(PCS_OFS_POLARITY_MISC, 8'h05);
    powerdown = 1'b1;
    @(negedge clk_sys);
    chk(16'({ale_out, pss_out, pup_en}), 16'h0007);
    wr(PCS_OFS_POLARITY_MISC, 8'h00);
    @(negedge clk_sys);
    chk(16'({ale_out, pss_out, pup_en}), 16'h0000);
    powerdown = 1'b0;
    ale_core = 1'b1;
    pss_core = 1'b1;
    @(negedge clk_sys);
    chk(16'({ale_out, pss_out}), 16'h0003);
    $display("power-down test done");
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    t_reset();
    t_regs();
    t_strobe();
    t_gpio();
    t_pdown();
    print_verdict();
  end

  // Hang guard far above the length of the test run
  initial begin
    #400000;
    bad_count++;
    print_verdict();
  end
endmodule
